// File: rtl/rtc_ctrl_pkg.sv
`default_nettype none
package rtc_ctrl_pkg;
   // clock and time base
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned TICK_HZ       = 32_768;
   localparam int unsigned TICK_DIV      = CLK_HZ / TICK_HZ;
   localparam int unsigned TICK_NS       = 30_518;
   localparam int unsigned LEAD_NS       = 244_000;
   localparam int unsigned ALARM_NS      = 30_500;
   localparam int unsigned LEAD_TICKS    = (LEAD_NS + TICK_NS - 1) / TICK_NS;
   localparam int unsigned ALARM_TICKS   = (ALARM_NS + TICK_NS - 1) / TICK_NS;
   localparam int unsigned DIV_W         = 15;
   localparam logic [14:0] UPDATE_POS    = 15'(LEAD_TICKS);

   // register indices; byte address is four times the index
   localparam logic [7:0]  IDX_RATE_BANK = 8'h0A;
   localparam logic [7:0]  IDX_TIME_OPT  = 8'h0B;
   localparam logic [7:0]  IDX_INT_STAT  = 8'h0C;
   localparam logic [7:0]  IDX_SUPPLY    = 8'h0D;
   localparam logic [7:0]  IDX_DAY_ALARM = 8'h49;

   // field positions
   localparam int unsigned BIT_SUMMER    = 0;
   localparam int unsigned BIT_HOUR24    = 1;
   localparam int unsigned BIT_UNUSED    = 3;
   localparam int unsigned BIT_UIE       = 4;
   localparam int unsigned BIT_AIE       = 5;
   localparam int unsigned BIT_PIE       = 6;
   localparam int unsigned BIT_FREEZE    = 7;
   localparam int unsigned BIT_NUMERIC   = 2;

   // values after reset
   localparam logic [3:0]  RATE_RST      = 4'h0;
   localparam logic [2:0]  BANK_RST      = 3'h2;
   localparam logic [7:0]  OPT_RST       = 8'h02;
   localparam logic [7:0]  DAY_ALARM_RST = 8'hC0;
   localparam logic [1:0]  DONT_CARE     = 2'h3;

   // divider bank codes
   localparam logic [2:0]  DV_BANK0      = 3'h2;
   localparam logic [2:0]  DV_BANK1      = 3'h3;
   localparam logic [2:0]  DV_BANK2      = 3'h4;
   localparam logic [2:0]  DV_TEST       = 3'h5;

   typedef struct packed {
      logic periodic;
      logic alarm;
      logic update;
   } flags_s;
endpackage
`default_nettype wire

// File: rtl/rtc_ctrl_status.sv
// Overview of operation
// - rate field picks divider tap for periodic flag; 0 off, 1/2 alias 8/9
// - master reset leaves rate and divider bank fields untouched
// - bank field 010/011/100 select banks 0/1/2; 101 is test and selects bank 0
// - 000/001 stop oscillator only in power failure; 110/111 hold divider reset
// - update pending reads 1 within 244 us of update, 0 while frozen
// - summer time enable bit steers the timekeeping spring/fall jumps
// - bit 1 selects 12 or 24 hour format, not touched by reset
// - bit 2 selects BCD or binary, not touched by reset
// - bit 3 of time option register always reads zero
// - master reset clears update, alarm and periodic enables
// - update done flag set at each update; interrupts only when enabled
// - alarm flag set after update when all alarm fields match
// - alarm flag appears 30.5 us after the matching update
// - update follows a periodic event by half period plus 244 us
// - freeze bit holds user time copy; clear lets updates run
// - status read and reset clear flags and irq; low nibble reads zero
// - periodic flag set on each rising transition of selected tap, once per tap period
// - pending flag is inverse of irq, any flag with its enable
// - supply valid reads 0 after low supply, 1 after read; rest zero
// - day alarm powers up C0h, master reset leaves it alone
// - day alarm top bits 11 make the day compare always match
`default_nettype none
module rtc_ctrl_status
   import rtc_ctrl_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        master_reset_in,
   input  wire logic        supply_low_in,
   input  wire logic        power_fail_in,
   input  wire logic        time_match_in,
   input  wire logic [7:0]  day_of_month_in,
   output logic             irq_n_out,
   output logic             update_strobe_out,
   output logic             freeze_out,
   output logic             summer_time_enable_out,
   output logic             hour24_out,
   output logic             numeric_format_select_out,
   output logic [1:0]       bank_select_out,
   output logic             osc_running_out
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic mr_meta_q, mr_q, low_meta_q, low_q, pf_meta_q, pf_q;

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         mr_meta_q  <= 1'b0;
         mr_q       <= 1'b0;
         low_meta_q <= 1'b0;
         low_q      <= 1'b0;
         pf_meta_q  <= 1'b0;
         pf_q       <= 1'b0;
      end else begin
         mr_meta_q  <= master_reset_in;
         mr_q       <= mr_meta_q;
         low_meta_q <= supply_low_in;
         low_q      <= low_meta_q;
         pf_meta_q  <= power_fail_in;
         pf_q       <= pf_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [10:0]      tick_cnt_q, tick_cnt_d;
   logic             tick_q, tick_d;
   logic [DIV_W-1:0] div_q, div_d;
   logic [3:0]       rate_q, rate_d;
   logic [2:0]       bank_q, bank_d;
   logic [7:0]       opt_q, opt_d;
   flags_s           flags_q, flags_d, ev, en;
   logic             supply_ok_q, supply_ok_d;
   logic             unlocked_q, unlocked_d;
   logic [7:0]       day_alarm_q, day_alarm_d;
   logic             alarm_wait_q, alarm_wait_d;
   logic [10:0]      alarm_age_q, alarm_age_d;
   logic             osc_run_q, osc_run_d;
   logic [1:0]       bank_sel_q, bank_sel_d;
   logic             update_q, update_d;
   logic [31:0]      prdata_q, prdata_d;
   logic             pready_q, pready_d;
   logic             pslverr_q, pslverr_d;
   logic             irq_n_q, irq_n_d;
   logic [2:0]       reported_q, reported_d;
   logic             osc_on, chain_rst, step, pending, day_match, mapped;
   logic             setup, access, wr, rd_stat, rd_supply;
   logic [7:0]       idx;
   logic [3:0]       plog;
   logic [DIV_W-1:0] pmask, phalf;

   ////////////////////////////////////////////////////////////////////////////
   // time base: 32.768 kHz enable and divider chain
   always_comb begin
      osc_on    = !(pf_q && (bank_q[2:1] == 2'b00));
      chain_rst = (bank_q[2:1] == 2'b11);
      osc_run_d  = osc_on;
      bank_sel_d = (bank_q == DV_BANK1) ? 2'd1 :
                   (bank_q == DV_BANK2) ? 2'd2 : 2'd0;
      tick_cnt_d = tick_cnt_q;
      tick_d     = 1'b0;
      if (osc_on) begin
         if (tick_cnt_q == 11'(TICK_DIV - 1)) begin
            tick_cnt_d = '0;
            tick_d     = 1'b1;
         end else begin
            tick_cnt_d = tick_cnt_q + 11'd1;
         end
      end
      step  = tick_q && !chain_rst;
      div_d = chain_rst ? '0 : (step ? div_q + 15'd1 : div_q);
      // tap period is 2**plog ticks
      unique case (rate_q)
         4'h1:    plog = 4'd7;
         4'h2:    plog = 4'd8;
         default: plog = rate_q - 4'd1;
      endcase
      pmask = DIV_W'((32'd1 << plog) - 32'd1);
      phalf = DIV_W'(32'd1 << (plog - 4'd1));
      // periodic event half a period ahead of second boundary plus lead
      ev.periodic = step && (rate_q != 4'h0)
                    && ((div_d & pmask) == phalf);
      update_d    = step && (div_d == UPDATE_POS);
      pending     = !chain_rst && osc_on && (div_q < UPDATE_POS)
                    && !opt_q[BIT_FREEZE];
      ev.update   = update_q;
      day_match   = (day_alarm_q[7:6] == DONT_CARE)
                    || (day_alarm_q[5:0] == day_of_month_in[5:0]);
      alarm_wait_d = alarm_wait_q;
      if (update_q && time_match_in && day_match) begin
         alarm_wait_d = 1'b1;
      end else if (alarm_wait_q && tick_q) begin
         alarm_wait_d = 1'b0;
      end
      ev.alarm = alarm_wait_q && tick_q;
      // cycles spent waiting for the tick that releases the alarm flag
      alarm_age_d = '0;
      if (alarm_wait_q) begin
         alarm_age_d = osc_on ? alarm_age_q + 11'd1 : alarm_age_q;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         tick_cnt_q   <= '0;
         tick_q       <= 1'b0;
         div_q        <= '0;
         update_q     <= 1'b0;
         alarm_wait_q <= 1'b0;
         alarm_age_q  <= '0;
         osc_run_q    <= 1'b1;
         bank_sel_q   <= 2'd0;
      end else begin
         tick_cnt_q   <= tick_cnt_d;
         tick_q       <= tick_d;
         div_q        <= div_d;
         update_q     <= update_d;
         alarm_wait_q <= alarm_wait_d;
         alarm_age_q  <= alarm_age_d;
         osc_run_q    <= osc_run_d;
         bank_sel_q   <= bank_sel_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave and register file
   always_comb begin
      idx       = paddr_in[9:2];
      mapped    = (paddr_in[31:10] == '0) && (paddr_in[1:0] == 2'b00)
                  && (idx == IDX_RATE_BANK || idx == IDX_TIME_OPT
                      || idx == IDX_INT_STAT || idx == IDX_SUPPLY
                      || idx == IDX_DAY_ALARM);
      setup     = psel_in && !penable_in;
      access    = psel_in && penable_in && pready_q;
      wr        = access && pwrite_in && mapped && unlocked_q;
      rd_stat   = access && !pwrite_in && mapped && (idx == IDX_INT_STAT);
      rd_supply = access && !pwrite_in && mapped && (idx == IDX_SUPPLY);
      en        = '{periodic: opt_q[BIT_PIE], alarm: opt_q[BIT_AIE],
                    update: opt_q[BIT_UIE]};

      rate_d      = rate_q;
      bank_d      = bank_q;
      opt_d       = opt_q;
      day_alarm_d = day_alarm_q;
      if (wr && idx == IDX_RATE_BANK) begin
         rate_d = pwdata_in[3:0];
         bank_d = pwdata_in[6:4];
      end
      if (wr && idx == IDX_TIME_OPT) begin
         opt_d = pwdata_in[7:0];
      end
      if (wr && idx == IDX_DAY_ALARM) begin
         day_alarm_d = pwdata_in[7:0];
      end
      opt_d[BIT_UNUSED] = 1'b0;
      if (mr_q) begin
         opt_d[BIT_PIE:BIT_UIE] = 3'b000;
      end

      // clear only what the read reported; a new event wins
      flags_d = flags_q;
      if (rd_stat) begin
         flags_d = flags_q & ~flags_s'(reported_q);
      end
      flags_d = flags_d | ev;
      if (mr_q) begin
         flags_d = '0;
      end
      irq_n_d = !(|(flags_d & {opt_d[BIT_PIE], opt_d[BIT_AIE],
                               opt_d[BIT_UIE]}));

      supply_ok_d = supply_ok_q;
      if (rd_supply) begin
         supply_ok_d = 1'b1;
      end
      if (low_q) begin
         supply_ok_d = 1'b0;
      end
      unlocked_d = unlocked_q || rd_supply;

      prdata_d   = prdata_q;
      reported_d = reported_q;
      pready_d   = setup;
      pslverr_d  = setup && !mapped;
      if (setup) begin
         prdata_d = '0;
         if (mapped && !pwrite_in) begin
            unique case (idx)
               IDX_RATE_BANK: prdata_d[7:0] = {pending, bank_q, rate_q};
               IDX_TIME_OPT:  prdata_d[7:0] = opt_q;
               IDX_INT_STAT:  prdata_d[7:0] = {!irq_n_q, flags_q, 4'h0};
               IDX_SUPPLY:    prdata_d[7:0] = {supply_ok_q, 7'h00};
               default:       prdata_d[7:0] = day_alarm_q;
            endcase
         end
         reported_d = flags_q;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         rate_q      <= RATE_RST;
         bank_q      <= BANK_RST;
         opt_q       <= OPT_RST;
         day_alarm_q <= DAY_ALARM_RST;
         flags_q     <= '0;
         irq_n_q     <= 1'b1;
         supply_ok_q <= 1'b0;
         unlocked_q  <= 1'b0;
         prdata_q    <= '0;
         reported_q  <= '0;
         pready_q    <= 1'b0;
         pslverr_q   <= 1'b0;
      end else begin
         rate_q      <= rate_d;
         bank_q      <= bank_d;
         opt_q       <= opt_d;
         day_alarm_q <= day_alarm_d;
         flags_q     <= flags_d;
         irq_n_q     <= irq_n_d;
         supply_ok_q <= supply_ok_d;
         unlocked_q  <= unlocked_d;
         prdata_q    <= prdata_d;
         reported_q  <= reported_d;
         pready_q    <= pready_d;
         pslverr_q   <= pslverr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   always_comb begin
      prdata_out                = prdata_q;
      pready_out                = pready_q;
      pslverr_out               = pslverr_q;
      irq_n_out                 = irq_n_q;
      update_strobe_out         = update_q;
      freeze_out                = opt_q[BIT_FREEZE];
      summer_time_enable_out    = opt_q[BIT_SUMMER];
      hour24_out                = opt_q[BIT_HOUR24];
      numeric_format_select_out = opt_q[BIT_NUMERIC];
      bank_select_out           = bank_sel_q;
      osc_running_out           = osc_run_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   mr_keeps_rate_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      mr_q && !wr |=> $stable(rate_q) && $stable(bank_q))
      else $error("master reset changed rate or bank");
   mr_clears_en_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      mr_q |=> opt_q[6:4] == 3'b000 && flags_q == '0)
      else $error("master reset left enables or flags");
   freeze_pend_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      opt_q[BIT_FREEZE] |-> !pending)
      else $error("update pending while frozen");
   unused_bit_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      pready_q && idx == IDX_TIME_OPT |-> prdata_q[3] == 1'b0)
      else $error("time option bit 3 read non-zero");
   update_flag_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      update_q && !mr_q |=> flags_q.update)
      else $error("update did not set update flag");
   alarm_delay_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      update_q && time_match_in && day_match && !mr_q
      |=> alarm_wait_q && !$rose(flags_q.alarm))
      else $error("alarm flag not held back one tick");
   alarm_window_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      alarm_age_q <= 11'(TICK_DIV))
      else $error("alarm flag held back longer than one tick");
   irq_match_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      irq_n_q == !(|(flags_q & en)))
      else $error("irq out of step with flags and enables");
   supply_low_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      low_q |=> !supply_ok_q)
      else $error("supply valid not cleared by low supply");
   write_lock_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      !unlocked_q |=> $stable(day_alarm_q) && $stable(rate_q))
      else $error("write taken before supply register read");
   event_kept_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      rd_stat && ev.periodic && !mr_q |=> flags_q.periodic)
      else $error("periodic event lost during status read");
   periodic_cov: cover property (@(posedge clock_in) disable iff (sys_rst_in)
      ev.periodic && opt_q[BIT_PIE]);
   alarm_cov: cover property (@(posedge clock_in) disable iff (sys_rst_in)
      ev.alarm);
   read_clear_cov: cover property (@(posedge clock_in) disable iff (sys_rst_in)
      rd_stat && !irq_n_q);
   freeze_cov: cover property (@(posedge clock_in) disable iff (sys_rst_in)
      opt_q[BIT_FREEZE] && pready_q);

endmodule // rtc_ctrl_status
`default_nettype wire

// File: tb/tb_rtc_ctrl_status.sv
`default_nettype none
module tb_rtc_ctrl_status
   import rtc_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic        e;
   } note_s;

   logic        clock_in, sys_rst_in, psel_in, penable_in, pwrite_in;
   logic [31:0] paddr_in, pwdata_in, prdata_out;
   logic        pready_out, pslverr_out, master_reset_in, supply_low_in, power_fail_in;
   logic        time_match_in, irq_n_out, update_strobe_out, freeze_out;
   logic [7:0]  day_of_month_in, v;
   logic        summer_time_enable_out, hour24_out, numeric_format_select_out, osc_running_out;
   logic [1:0]  bank_select_out;
   int          n_errors, samples_checked, seed, k;
   note_s       q[$];
   note_s       n;

   rtc_ctrl_status u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .master_reset_in(master_reset_in),
      .supply_low_in(supply_low_in), .power_fail_in(power_fail_in),
      .time_match_in(time_match_in), .day_of_month_in(day_of_month_in),
      .irq_n_out(irq_n_out), .update_strobe_out(update_strobe_out), .freeze_out(freeze_out),
      .summer_time_enable_out(summer_time_enable_out), .hour24_out(hour24_out),
      .numeric_format_select_out(numeric_format_select_out),
      .bank_select_out(bank_select_out), .osc_running_out(osc_running_out));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one apb transfer; the expectation is queued for the monitor
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      input logic [31:0] exp, input logic [31:0] msk, input logic err);
      q.push_back('{exp, msk, err});
      @(posedge clock_in);
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= wr;
      paddr_in   <= {22'h0, idx, 2'b00};
      pwdata_in  <= wd;
      @(posedge clock_in);
      penable_in <= 1'b1;
      k = 0;
      do begin
         @(posedge clock_in);
         k++;
      end while (pready_out !== 1'b1 && k < 16);
      if (pready_out !== 1'b1) begin
         n_errors++;
         report_and_stop();
      end
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd, 32'h0, 32'h0, 1'b0);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] msk);
      apb(1'b0, idx, 32'h0, exp, msk, 1'b0);
   endtask

   task automatic wait_irq(input int bound);
      k = 0;
      while (irq_n_out !== 1'b0 && k < bound) begin
         @(posedge clock_in);
         k++;
      end
      if (irq_n_out !== 1'b0) begin
         n_errors++;
         report_and_stop();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      forever begin
         @(posedge clock_in);
         if (psel_in && penable_in && pready_out === 1'b1) begin
            if (q.size() == 0) begin
               chk("queue", 32'h1, 32'h0);
            end else begin
               n = q.pop_front();
               chk("prdata", n.d & n.m, prdata_out & n.m);
               chk("pslverr", 32'(n.e), 32'(pslverr_out));
            end
         end
      end
   end

   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   initial begin
      seed = 6761;
      n_errors = 0;
      samples_checked = 0;
      {sys_rst_in, time_match_in} = 2'b11;
      {psel_in, penable_in, pwrite_in, master_reset_in, supply_low_in, power_fail_in} = 6'h00;
      paddr_in = 32'h0;
      pwdata_in = 32'h0;
      day_of_month_in = 8'($random(seed));
      repeat (8) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      @(posedge clock_in);
      chk("hour24", 32'h1, 32'(hour24_out));
      chk("irq_n", 32'h1, 32'(irq_n_out));
      rd(IDX_DAY_ALARM, 32'hC0, 32'hFF);
      wr(IDX_RATE_BANK, 32'h36);
      rd(IDX_RATE_BANK, 32'h20, 32'h7F);
      apb(1'b0, 8'h20, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
      k = 0;
      while (update_strobe_out !== 1'b1 && k < 20000) begin
         @(posedge clock_in);
         k++;
      end
      if (update_strobe_out !== 1'b1) begin
         n_errors++;
         report_and_stop();
      end
      chk("update seen", 32'h1, 32'(update_strobe_out));
      repeat (1600) @(posedge clock_in);
      chk("irq_n masked", 32'h1, 32'(irq_n_out));
      rd(IDX_INT_STAT, 32'h30, 32'hFF);
      rd(IDX_INT_STAT, 32'h00, 32'hFF);
      rd(IDX_SUPPLY, 32'h00, 32'hFF);
      rd(IDX_SUPPLY, 32'h80, 32'hFF);
      supply_low_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      supply_low_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      rd(IDX_SUPPLY, 32'h00, 32'hFF);
      rd(IDX_SUPPLY, 32'h80, 32'hFF);
      wr(IDX_TIME_OPT, 32'h7F);
      rd(IDX_TIME_OPT, 32'h77, 32'hFF);
      chk("summer", 32'h1, 32'(summer_time_enable_out));
      chk("numeric", 32'h1, 32'(numeric_format_select_out));
      wr(IDX_TIME_OPT, 32'hF7);
      rd(IDX_RATE_BANK, 32'h00, 32'h80);
      chk("freeze", 32'h1, 32'(freeze_out));
      v = 8'($random(seed)) & 8'hDF;
      wr(IDX_DAY_ALARM, {24'h0, v});
      wr(IDX_TIME_OPT, 32'h77);
      wr(IDX_RATE_BANK, 32'h36);
      repeat (2) @(posedge clock_in);
      chk("bank", 32'h1, 32'(bank_select_out));
      master_reset_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      master_reset_in <= 1'b0;
      repeat (8) @(posedge clock_in);
      rd(IDX_TIME_OPT, 32'h07, 32'hFF);
      rd(IDX_RATE_BANK, 32'h36, 32'h7F);
      rd(IDX_DAY_ALARM, {24'h0, v}, 32'hFF);
      for (int c = 0; c < 8; c++) begin
         wr(IDX_RATE_BANK, 32'(c) << 4);
         repeat (3) @(posedge clock_in);
         chk("bank", (c == 3) ? 32'h1 : (c == 4) ? 32'h2 : 32'h0, 32'(bank_select_out));
         chk("osc", 32'h1, 32'(osc_running_out));
         power_fail_in <= 1'b1;
         repeat (5) @(posedge clock_in);
         chk("osc fail", (c < 2) ? 32'h0 : 32'h1, 32'(osc_running_out));
         power_fail_in <= 1'b0;
         repeat (5) @(posedge clock_in);
      end
      // rate code 3: four ticks between periodic events
      wr(IDX_RATE_BANK, 32'h23);
      wr(IDX_TIME_OPT, 32'h42);
      rd(IDX_INT_STAT, 32'h0, 32'h0);
      repeat (3) @(posedge clock_in);
      wait_irq(4 * 1525 + 200);
      rd(IDX_INT_STAT, 32'hC0, 32'hFF);
      repeat (3) @(posedge clock_in);
      chk("irq_n cleared", 32'h1, 32'(irq_n_out));
      wr(IDX_RATE_BANK, 32'h20);
      repeat (4) @(posedge clock_in);
      chk("queue empty", 32'h0, 32'(q.size()));
      report_and_stop();
   end
endmodule // tb_rtc_ctrl_status
`default_nettype wire
